/* logic/dpm_pkg.sv */
// Constants, register map and carrier types for the dual PWM mode/trigger block.
// Assumes a 32-bit APB master and a single 10 MHz clock.
package dpm_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CNT_W  = 16;
    // Register byte offsets
    localparam logic [7:0] OFF_CFG_A   = 8'h00;
    localparam logic [7:0] OFF_CFG_B   = 8'h04;
    localparam logic [7:0] OFF_MODE    = 8'h08;
    localparam logic [7:0] OFF_PER_A   = 8'h0C;
    localparam logic [7:0] OFF_DUTY_A  = 8'h10;
    localparam logic [7:0] OFF_PER_B   = 8'h14;
    localparam logic [7:0] OFF_DUTY_B  = 8'h18;
    localparam logic [7:0] OFF_DEAD    = 8'h1C;
    localparam logic [7:0] OFF_STATUS  = 8'h20;
    localparam logic [7:0] OFF_IRQ     = 8'h24;
    localparam logic [7:0] OFF_MASK    = 8'h28;
    // Field width and positions
    localparam int CFG_W        = 7;
    localparam int MODE_COOP    = 0;
    localparam int MODE_DT      = 1;
    // Reset values
    localparam logic [15:0] PER_RST  = 16'hFFFF;
    localparam logic [15:0] DUTY_RST = 16'h7FFF;
    localparam logic [15:0] DEAD_RST = 16'h0000;
    // Start-mode field
    localparam logic [1:0] SM_SW     = 2'b00;
    localparam logic [1:0] SM_SW_LVL = 2'b01;
    localparam logic [1:0] SM_EXT    = 2'b10;
    localparam logic [1:0] SM_SW_CLR = 2'b11;
    // Per-channel control word, as written to a CFG register
    typedef struct packed {
        logic       trigger_pin_select;
        logic [1:0] trigger_edge_select;
        logic [1:0] start_mode_select;
        logic       one_shot_select;
        logic       run_control;
    } dpm_cfg_s;
    // Decoded start/stop/clear controls
    typedef struct packed {
        logic go;
        logic clr;
        logic start;
        logic stop;
    } dpm_ctl_s;
endpackage

/* logic/dpm_top.sv */
// Dual PWM channel pair with mode selection and start/stop/clear trigger control.
// Assumes an APB master on clock and asynchronous trigger pins.
//
// Operation
// R01: Standalone repeat mode runs each channel on its own, period after period.
// R02: Standalone one-shot mode stops each channel after a single period; in start mode 01 an active trigger level keeps the channel running.
// R03: Cooperation without dead time shares one period; each channel keeps its own duty.
// R04: Cooperation with one-shot stops both channels after one period; in start mode 01 an active trigger level keeps both running.
// R05: Cooperation with dead time leaves an interval where both outputs are off.
// R06: Start mode 00 uses only the run bit; triggers are ignored.
// R07: Start mode 01 starts on the active trigger level, stops on the other; run bit also works.
// R08: Start mode 01 with edge field 11 ignores the trigger; only the run bit acts.
// R09: Start mode 10 starts on one edge and stops and clears on the other.
// R10: Start mode 10 with edge field 00 keeps the channel idle.
// R11: Start mode 11 uses the run bit and clears on the selected trigger edges.
// R12: The pin select bit picks which trigger pin drives hardware control.
// R13: In cooperation the first channel's settings govern both channels.
// R14: The selected trigger is synchronised before any level or edge detection.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dpm_top
    import dpm_pkg::*;
#(
    parameter int W = dpm_pkg::CNT_W
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        trigger_input_a,
    input  wire logic        trigger_input_b,
    output logic             pwm_channel_a,
    output logic             pwm_channel_b,
    output logic             irq
);
    import dpm_pkg::*;

    dpm_cfg_s         cfg [2];
    logic     [W-1:0] per [2];
    logic     [W-1:0] duty [2];
    logic     [W-1:0] cnt [2];
    logic     [W-1:0] dead;
    logic             coop, dt_en;
    logic       [1:0] hw_run, running, irq_stat, irq_mask;
    logic       [1:0] trig_s1, trig_s2, lvl_q;
    logic       [1:0] wrap, done, rise, fall, lvl;
    dpm_cfg_s         eff [2];
    dpm_ctl_s         ctl [2];
    logic     [W-1:0] eff_per [2];
    logic     [W-1:0] next_cnt [2];
    logic       [2:0] sync_fill;

    // Start/stop/clear decode for one channel
    function automatic dpm_ctl_s ctl_decode(dpm_cfg_s c, logic l, logic r, logic f, logic hr);
        dpm_ctl_s o;
        o = '0;
        unique case (c.start_mode_select)
            SM_SW: o.go = c.run_control; // [R06]
            SM_SW_LVL: begin
                unique case (c.trigger_edge_select)
                    2'b01:   o.go = c.run_control | l; // [R07]
                    2'b10:   o.go = c.run_control | ~l; // [R07]
                    default: o.go = c.run_control; // [R08]
                endcase
            end
            SM_EXT: begin
                if (c.trigger_edge_select == 2'b01) begin
                    o.start = r; // [R09]
                    o.stop  = f;
                end else if (c.trigger_edge_select == 2'b10) begin
                    o.start = f; // [R09]
                    o.stop  = r;
                end
                o.clr = o.stop;
                o.go  = (c.trigger_edge_select == 2'b01 || c.trigger_edge_select == 2'b10)
                        && hr && !o.stop; // [R10]
            end
            SM_SW_CLR: begin
                o.go  = c.run_control; // [R11]
                o.clr = (c.trigger_edge_select[0] & f) | (c.trigger_edge_select[1] & r);
            end
        endcase
        return o;
    endfunction

    // APB decode
    wire       setup    = psel & ~penable;
    wire       wr_en    = psel & penable & pready & pwrite;
    wire       rd_done  = psel & penable & pready & ~pwrite;
    wire       hit_a    = paddr == OFF_CFG_A;
    wire       hit_b    = paddr == OFF_CFG_B;
    wire [1:0] hit_cfg  = {hit_b, hit_a};
    wire [1:0] hit_per  = {paddr == OFF_PER_B, paddr == OFF_PER_A};
    wire [1:0] hit_duty = {paddr == OFF_DUTY_B, paddr == OFF_DUTY_A};
    wire       hit_irq  = paddr == OFF_IRQ;
    wire       mapped   = (paddr[1:0] == 2'b00) && (paddr <= OFF_MASK);
    wire       irq_rc   = rd_done & hit_irq;
    // A read clears only the bits it returned; an event in the read window survives
    wire [1:0] next_irq_stat = (irq_rc ? irq_stat & ~prdata[1:0] : irq_stat) | wrap;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            OFF_CFG_A:  rd_mux[CFG_W-1:0] = cfg[0];
            OFF_CFG_B:  rd_mux[CFG_W-1:0] = cfg[1];
            OFF_MODE:   rd_mux[1:0] = {dt_en, coop};
            OFF_PER_A:  rd_mux[W-1:0] = per[0];
            OFF_DUTY_A: rd_mux[W-1:0] = duty[0];
            OFF_PER_B:  rd_mux[W-1:0] = per[1];
            OFF_DUTY_B: rd_mux[W-1:0] = duty[1];
            OFF_DEAD:   rd_mux[W-1:0] = dead;
            OFF_STATUS: rd_mux[3:0] = {hw_run, running};
            OFF_IRQ:    rd_mux[1:0] = irq_stat;
            OFF_MASK:   rd_mux[1:0] = irq_mask;
            default:    rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= setup ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            coop     <= 1'b0;
            dt_en    <= 1'b0;
            dead     <= DEAD_RST;
            irq_mask <= 2'b00;
            irq_stat <= 2'b00;
            irq      <= 1'b0;
        end else begin
            if (wr_en && paddr == OFF_MODE) begin
                coop  <= pwdata[MODE_COOP];
                dt_en <= pwdata[MODE_DT];
            end
            if (wr_en && paddr == OFF_DEAD)
                dead <= pwdata[W-1:0];
            if (wr_en && paddr == OFF_MASK)
                irq_mask <= pwdata[1:0];
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & irq_mask);
        end
    end

    // Trigger pin synchronisers [R14]
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trig_s1   <= 2'b00;
            trig_s2   <= 2'b00;
            sync_fill <= 3'b000;
        end else begin
            trig_s1   <= {trigger_input_b, trigger_input_a};
            trig_s2   <= trig_s1;
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    // Channel b follows channel a settings in cooperation [R13]
    assign eff[0]     = cfg[0];
    assign eff[1]     = coop ? cfg[0] : cfg[1];
    assign eff_per[0] = per[0];
    assign eff_per[1] = coop ? per[0] : per[1];

    for (genvar n = 0; n < 2; n++) begin : g_ch
        wire rst_run = done[n] & ~(coop & (n == 1));
        assign lvl[n]  = eff[n].trigger_pin_select ? trig_s2[1] : trig_s2[0]; // [R12]
        // Edges count only once the synchroniser and lvl_q hold real pin levels
        assign rise[n] = sync_fill[2] & lvl[n] & ~lvl_q[n];
        assign fall[n] = sync_fill[2] & ~lvl[n] & lvl_q[n];
        assign ctl[n]  = ctl_decode(eff[n], lvl[n], rise[n], fall[n],
                                    coop ? hw_run[0] : hw_run[n]);
        assign wrap[n] = ctl[n].go && !ctl[n].clr && cnt[n] >= eff_per[n];
        assign done[n] = wrap[n] & eff[n].one_shot_select; // [R02] [R04]
        assign next_cnt[n] = (ctl[n].clr || wrap[n]) ? '0 // [R01] [R11]
                           : ctl[n].go ? cnt[n] + 1'b1 : cnt[n];

        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                cfg[n]     <= '0;
                per[n]     <= PER_RST;
                duty[n]    <= DUTY_RST;
                cnt[n]     <= '0;
                lvl_q[n]   <= 1'b0;
                hw_run[n]  <= 1'b0;
                running[n] <= 1'b0;
            end else begin
                lvl_q[n]   <= lvl[n];
                running[n] <= ctl[n].go;
                if (wr_en && hit_cfg[n])
                    cfg[n] <= dpm_cfg_s'(pwdata[CFG_W-1:0]);
                else if (rst_run)
                    cfg[n].run_control <= 1'b0;
                if (wr_en && hit_per[n])
                    per[n] <= pwdata[W-1:0];
                if (wr_en && hit_duty[n])
                    duty[n] <= pwdata[W-1:0];
                if (ctl[n].start)
                    hw_run[n] <= 1'b1; // [R09]
                else if (ctl[n].stop || done[n])
                    hw_run[n] <= 1'b0;
                // Channel b takes channel a's count in cooperation
                cnt[n] <= (coop && n == 1) ? next_cnt[0] : next_cnt[n]; // [R03]
            end
        end
    end

    // Output shaping; dead time opens a gap after each falling edge of channel a and of channel b [R05]
    wire [W:0] b_edge   = {1'b0, duty[0]} + {1'b0, dead};
    wire       dt_mode  = coop & dt_en;
    wire       a_std    = cnt[0] <= duty[0];
    wire       b_std    = cnt[1] <= duty[1]; // [R03]
    wire       a_dt     = (cnt[0] >= dead) && a_std;
    wire       b_dt     = {1'b0, cnt[0]} > b_edge;
    wire       next_a   = ctl[0].go & (dt_mode ? a_dt : a_std);
    wire       next_b   = ctl[1].go & (dt_mode ? b_dt : b_std);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pwm_channel_a <= 1'b0;
            pwm_channel_b <= 1'b0;
        end else begin
            pwm_channel_a <= next_a;
            pwm_channel_b <= next_b;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_sw_ignores_trig: assert property ( // [R06]
        eff[0].start_mode_select == SM_SW |-> ctl[0].go == cfg[0].run_control)
        else $error("software mode reacts to trigger");
    chk_lvl_starts: assert property ( // [R07]
        eff[0].start_mode_select == SM_SW_LVL && eff[0].trigger_edge_select == 2'b01
        && lvl[0] |-> ctl[0].go)
        else $error("active level did not run channel");
    chk_lvl_ignored: assert property ( // [R08]
        eff[0].start_mode_select == SM_SW_LVL && eff[0].trigger_edge_select == 2'b11
        |-> ctl[0].go == eff[0].run_control)
        else $error("edge field 11 did not ignore trigger");
    chk_ext_rise_start: assert property ( // [R09]
        eff[0].start_mode_select == SM_EXT && eff[0].trigger_edge_select == 2'b01
        && rise[0] |=> hw_run[0])
        else $error("rising edge did not start channel");
    chk_ext_disabled: assert property ( // [R10]
        eff[0].start_mode_select == SM_EXT && eff[0].trigger_edge_select == 2'b00
        |=> $stable(cnt[0]))
        else $error("disabled external mode counted");
    chk_edge_clear: assert property ( // [R11]
        eff[0].start_mode_select == SM_SW_CLR && eff[0].trigger_edge_select == 2'b11
        && (rise[0] || fall[0]) |=> cnt[0] == '0)
        else $error("both-edge clear missed");
    chk_oneshot_stop: assert property ( // [R02] [R04]
        done[0] && !(wr_en && hit_a) |=> !cfg[0].run_control ##1 !running[0])
        else $error("one-shot did not stop");
    chk_repeat_wrap: assert property ( // [R01]
        wrap[0] && !eff[0].one_shot_select |=> cnt[0] == '0 && running[0])
        else $error("repeat mode did not restart period");
    chk_coop_common: assert property ( // [R03] [R13]
        coop && $past(coop) |-> cnt[0] == cnt[1])
        else $error("cooperating counters diverged");
    chk_dead_gap: assert property ( // [R05]
        $past(dt_mode) && dt_mode |-> !(pwm_channel_a && pwm_channel_b))
        else $error("both outputs on under dead time");
    chk_lvl_low_stops: assert property ( // [R07]
        eff[0].start_mode_select == SM_SW_LVL && eff[0].trigger_edge_select == 2'b01
        && !lvl[0] && !eff[0].run_control |-> !ctl[0].go)
        else $error("inactive level kept channel running");
    chk_ext_stop_clear: assert property ( // [R09]
        eff[0].start_mode_select == SM_EXT
        && ((eff[0].trigger_edge_select == 2'b01 && fall[0])
        || (eff[0].trigger_edge_select == 2'b10 && rise[0]))
        |=> !hw_run[0] && cnt[0] == '0)
        else $error("stop edge did not stop and clear");
    chk_ext_idle_out: assert property ( // [R10]
        eff[0].start_mode_select == SM_EXT && eff[0].trigger_edge_select == 2'b00
        |=> !pwm_channel_a)
        else $error("disabled external mode drove output");
    chk_pin_b_level: assert property ( // [R12]
        eff[0].start_mode_select == SM_SW_LVL && eff[0].trigger_edge_select == 2'b01
        && eff[0].trigger_pin_select && trig_s2[1] |-> ctl[0].go)
        else $error("selected pin b level ignored");
    chk_coop_oneshot: assert property ( // [R04] [R13]
        coop && done[0] && !wr_en |-> ##2 !running[1])
        else $error("cooperating channel b kept running");
    chk_sync_chain: assert property ( // [R14]
        trig_s2 == $past(trig_s1))
        else $error("trigger synchroniser skipped a stage");
endmodule
`default_nettype wire

/* dv/dpm_pins_model.sv */
// Far-side model: drives the two trigger pins and counts PWM output activity.
// Assumes the bench sets pin levels just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dpm_pins_model (
    input  wire logic clock,
    input  wire logic pwm_a,
    input  wire logic pwm_b,
    input  wire logic clr,
    output var logic  trig_a,
    output var logic  trig_b,
    output var int    hi_a,
    output var int    hi_b,
    output var int    hi_both
);
    initial begin
        trig_a = 1'b0;
        trig_b = 1'b0;
    end
    task automatic set_pins(input logic a, input logic b);
        trig_a <= a;
        trig_b <= b;
    endtask
    // High cycles per output, and cycles with both outputs high
    always @(posedge clock) begin
        hi_a    <= clr ? 0 : hi_a + int'(pwm_a);
        hi_b    <= clr ? 0 : hi_b + int'(pwm_b);
        hi_both <= clr ? 0 : hi_both + int'(pwm_a & pwm_b);
    end
endmodule
`default_nettype wire

/* dv/dpm_top_tb.sv */
// Bench for the dual PWM block: a table of trigger cases, then PWM and interrupt cases.
// Assumes zero-wait APB answers and the far-side pin model.
`timescale 1ns/1ps
`default_nettype none
module dpm_top_tb;
    import dpm_pkg::*;
    logic        clock;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trigger_input_a;
    logic        trigger_input_b;
    logic        pwm_channel_a;
    logic        pwm_channel_b;
    logic        irq;
    logic        clr;
    int          hi_a;
    int          hi_b;
    int          hi_both;
    int          err_total;
    int          checks_done;
    int          cycles;
    logic [31:0] q;
    logic        e;
    // Rows: control word, pin a, pin b, expected counting flag of channel a
    logic [9:0]  rows [14] = '{10'h004, 10'h009, 10'h0A5, 10'h0A0, 10'h121, 10'h1A4,
        10'h1A9, 10'h2A4, 10'h2A3, 10'h0C5, 10'h141, 10'h04C, 10'h1E9, 10'h144};

    dpm_top i_dpm_top (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .trigger_input_a, .trigger_input_b, .pwm_channel_a,
        .pwm_channel_b, .irq);
    dpm_pins_model i_dpm_pins_model (.clock(clock), .pwm_a(pwm_channel_a),
        .pwm_b(pwm_channel_b), .clr(clr), .trig_a(trigger_input_a),
        .trig_b(trigger_input_b), .hi_a(hi_a), .hi_b(hi_b), .hi_both(hi_both));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; pready, prdata and pslverr are taken at the rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(q & m, x);
    endtask
    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic clr_cnt();
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        clr = 1'b0;
        for (int i = 0; i < 14; i++) begin
            do_reset();
            wr(OFF_CFG_A, 32'(rows[i][9:3]));
            i_dpm_pins_model.set_pins(rows[i][2], rows[i][1]);
            repeat (8) @(posedge clock);
            rd(OFF_STATUS, 32'h0000_0001, 32'(rows[i][0]));
        end
        $display("test trigger table done");
        do_reset();
        rd(OFF_PER_A, 32'hFFFF_FFFF, 32'h0000_FFFF);
        rd(OFF_DUTY_A, 32'hFFFF_FFFF, 32'h0000_7FFF);
        rd(OFF_DEAD, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 8'h2C, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        chk(q, 32'h0000_0000);
        @(negedge clock);
        chk(32'(pready), 32'h0000_0000);
        $display("test registers done");
        wr(OFF_PER_A, 32'h0000_0009);
        wr(OFF_DUTY_A, 32'h0000_0003);
        wr(OFF_PER_B, 32'h0000_0004);
        wr(OFF_DUTY_B, 32'h0000_0000);
        wr(OFF_CFG_B, 32'h0000_0001);
        wr(OFF_CFG_A, 32'h0000_0001);
        look(20);
        clr_cnt();
        look(40);
        chk(32'(hi_a), 32'h0000_0010);
        chk(32'(hi_b), 32'h0000_0008);
        $display("test repeat done");
        wr(OFF_MODE, 32'h0000_0001);
        wr(OFF_DUTY_B, 32'h0000_0006);
        wr(OFF_CFG_B, 32'h0000_0000);
        look(20);
        clr_cnt();
        look(40);
        chk(32'(hi_a), 32'h0000_0010);
        chk(32'(hi_b), 32'h0000_001C);
        wr(OFF_DEAD, 32'h0000_0002);
        wr(OFF_MODE, 32'h0000_0003);
        look(20);
        clr_cnt();
        look(40);
        chk(32'(hi_a), 32'h0000_0008);
        chk(32'(hi_b), 32'h0000_0010);
        chk(32'(hi_both), 32'h0000_0000);
        $display("test cooperation done");
        do_reset();
        wr(OFF_PER_A, 32'h0000_0009);
        wr(OFF_DUTY_A, 32'h0000_0003);
        wr(OFF_PER_B, 32'h0000_0004);
        wr(OFF_DUTY_B, 32'h0000_0001);
        wr(OFF_MASK, 32'h0000_0001);
        clr_cnt();
        wr(OFF_CFG_B, 32'h0000_0003);
        look(30);
        chk(32'(hi_b), 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000);
        rd(OFF_IRQ, 32'h0000_0003, 32'h0000_0002);
        wr(OFF_MODE, 32'h0000_0001);
        wr(OFF_DUTY_B, 32'h0000_0006);
        clr_cnt();
        wr(OFF_CFG_A, 32'h0000_0003);
        look(30);
        chk(32'(hi_a), 32'h0000_0004);
        chk(32'(hi_b), 32'h0000_0007);
        chk(32'(irq), 32'h0000_0001);
        rd(OFF_CFG_A, 32'h0000_0001, 32'h0000_0000);
        rd(OFF_IRQ, 32'h0000_0001, 32'h0000_0001);
        look(2);
        chk(32'(irq), 32'h0000_0000);
        $display("test one-shot and interrupt done");
        summarize();
    end
endmodule
`default_nettype wire
